/* design/smk_pkg.sv */
/*
  Package for the security mode key unlock block: modes, key defaults,
  key store indices and the carrier structs.
  Assumes one system clock domain and no software-visible registers.
*/
package smk_pkg;

  localparam int KEY_W = 16;
  localparam int CMD_W = 16;
  localparam int KEY_IDX_W = 2;

  // Key store indices
  localparam logic [1:0] KIDX_UNSEAL_0 = 2'h0;
  localparam logic [1:0] KIDX_UNSEAL_1 = 2'h1;
  localparam logic [1:0] KIDX_FULL_0 = 2'h2;
  localparam logic [1:0] KIDX_FULL_1 = 2'h3;

  // Reset values of the nonvolatile key store
  localparam logic [15:0] UNSEAL_KEY0_RST = 16'h3672;
  localparam logic [15:0] UNSEAL_KEY1_RST = 16'h0414;
  localparam logic [15:0] FULL_KEY0_RST = 16'hffff;
  localparam logic [15:0] FULL_KEY1_RST = 16'hffff;

  // Flash block mode select subcommand code
  localparam logic [7:0] FLASH_BLOCK_MODE_CMD = 8'h61;

  typedef enum logic [2:0] {
    SMK_SEALED = 3'b001,
    SMK_UNSEALED = 3'b010,
    SMK_FULL = 3'b100
  } smk_mode_e;

  // One control-interface word write
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } smk_ctl_wr_s;

  // Key store update request
  typedef struct packed {
    logic valid;
    logic [1:0] idx;
    logic [15:0] data;
  } smk_key_wr_s;

  // Access permissions
  typedef struct packed {
    logic gen_rd;
    logic gen_wr;
    logic blk_a_rd;
    logic blk_a_wr;
    logic blk_b_rd;
    logic blk_b_wr;
  } smk_perm_s;

endpackage

/* design/smk_unlock.sv */
/*
  Security mode key unlock: sealed / unsealed / full-access state machine,
  key compare, key store, permissions and flash block mode command gating.
  Assumes control word writes and key updates arrive from logic on ref_clk.
*/
// Function
// - Each unseal or full-access mode change needs its correct key pair; seal_req seals without a key.
// - Key words must arrive back to back.
// - Sealed flag stays one while sealed.
// - Unseal pair clears sealed flag, enters unsealed.
// - Full pair clears full-access flag, enters full.
// - Two 16-bit words per level, kept stored.
// - Key updates allowed only in full-access.
// - Received words compared byte-swapped to stored.
// - Data and block permissions follow security mode.
// - Flash block mode command refused while sealed.
`timescale 1ns/10ps
module smk_unlock (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire smk_pkg::smk_ctl_wr_s ctl_wr,
  input wire smk_pkg::smk_key_wr_s key_wr,
  input wire logic seal_req,
  input wire logic flash_block_mode_select,
  output logic sealed_flag,
  output logic full_access_state_flag,
  output logic key_wr_ack,
  output logic key_wr_nack,
  output logic flash_block_mode_ack,
  output logic flash_block_mode_nack,
  output smk_pkg::smk_perm_s perm
);
  import smk_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Key store, nonvolatile copy modelled as registers

  logic [15:0] key_store_r [4];
  logic [15:0] key_store_nxt [4];
  smk_mode_e mode_r;
  smk_mode_e mode_nxt;
  logic first_ok_r;
  logic first_ok_nxt;
  logic first_full_r;
  logic first_full_nxt;

  function automatic logic [15:0] swap16(input logic [15:0] w);
    swap16 = {w[7:0], w[15:8]};
  endfunction

  wire key_upd_ok = key_wr.valid && (mode_r == SMK_FULL);

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      key_store_nxt[i] = key_store_r[i];
    end
    if (key_upd_ok) begin
      key_store_nxt[key_wr.idx] = key_wr.data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_store_r[KIDX_UNSEAL_0] <= UNSEAL_KEY0_RST;
      key_store_r[KIDX_UNSEAL_1] <= UNSEAL_KEY1_RST;
      key_store_r[KIDX_FULL_0] <= FULL_KEY0_RST;
      key_store_r[KIDX_FULL_1] <= FULL_KEY1_RST;
    end else begin
      for (int i = 0; i < 4; i++) begin
        key_store_r[i] <= key_store_nxt[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key compare

  // Host sends key 1 first, key 0 second, each byte-swapped
  wire [15:0] rx_word = swap16(ctl_wr.data);
  wire hit_un1 = rx_word == key_store_r[KIDX_UNSEAL_1];
  wire hit_un0 = rx_word == key_store_r[KIDX_UNSEAL_0];
  wire hit_fa1 = rx_word == key_store_r[KIDX_FULL_1];
  wire hit_fa0 = rx_word == key_store_r[KIDX_FULL_0];
  // Unseal pair only meaningful while sealed; full pair from unsealed
  wire want_un = mode_r == SMK_SEALED;
  wire want_fa = mode_r == SMK_UNSEALED;
  wire second_un = ctl_wr.valid && first_ok_r && !first_full_r && hit_un0;
  wire second_fa = ctl_wr.valid && first_ok_r && first_full_r && hit_fa0;

  always_comb begin
    mode_nxt = mode_r;
    first_ok_nxt = first_ok_r;
    first_full_nxt = first_full_r;
    if (ctl_wr.valid) begin
      // Any write ends a pending first word, matched or not
      first_ok_nxt = 1'b0;
      first_full_nxt = 1'b0;
      if (second_un) begin
        mode_nxt = SMK_UNSEALED;
      end else if (second_fa) begin
        mode_nxt = SMK_FULL;
      end else if (want_un && hit_un1) begin
        first_ok_nxt = 1'b1;
      end else if (want_fa && hit_fa1) begin
        first_ok_nxt = 1'b1;
        first_full_nxt = 1'b1;
      end
    end
    // Seal wins over a key pair landing in the same cycle
    if (seal_req) begin
      mode_nxt = SMK_SEALED;
      first_ok_nxt = 1'b0;
      first_full_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= SMK_SEALED;
      first_ok_r <= 1'b0;
      first_full_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      first_ok_r <= first_ok_nxt;
      first_full_r <= first_full_nxt;
    end
  end

  wire sealed_w = mode_nxt == SMK_SEALED;
  wire fas_w = mode_nxt != SMK_FULL;
  wire fbm_ok = flash_block_mode_select && (mode_r != SMK_SEALED);
  smk_perm_s perm_nxt;

  always_comb begin
    case (mode_nxt)
      SMK_SEALED: perm_nxt = 6'h0b;
      SMK_UNSEALED: perm_nxt = 6'h3f;
      SMK_FULL: perm_nxt = 6'h3f;
      default: perm_nxt = 6'h0b;
    endcase
  end

  // Outputs registered; flags track mode in the same cycle as mode_r
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sealed_flag <= 1'b1;
      full_access_state_flag <= 1'b1;
      key_wr_ack <= 1'b0;
      key_wr_nack <= 1'b0;
      flash_block_mode_ack <= 1'b0;
      flash_block_mode_nack <= 1'b0;
      perm <= 6'h0b;
    end else begin
      sealed_flag <= sealed_w;
      full_access_state_flag <= fas_w;
      key_wr_ack <= key_upd_ok;
      key_wr_nack <= key_wr.valid && !key_upd_ok;
      flash_block_mode_ack <= fbm_ok;
      flash_block_mode_nack <= flash_block_mode_select && !fbm_ok;
      perm <= perm_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sealed_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sealed_flag == (mode_r == SMK_SEALED))
    else $error("sealed flag disagrees with mode");
  unseal_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (second_un && !seal_req) |=> (mode_r == SMK_UNSEALED) && !sealed_flag)
    else $error("unseal pair did not unseal");
  full_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (second_fa && !seal_req) |=> (mode_r == SMK_FULL) && !full_access_state_flag)
    else $error("full pair did not grant full access");
  mode_change_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_r != $past(mode_r) && mode_r != SMK_SEALED) |-> $past(ctl_wr.valid && first_ok_r))
    else $error("mode changed without key pair");
  back_to_back_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctl_wr.valid && !(want_un && hit_un1) && !(want_fa && hit_fa1)) |=> !first_ok_r)
    else $error("pending key survived a write");
  discard_seq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctl_wr.valid && first_ok_r && !second_un && !second_fa && !seal_req)
    |=> mode_r == $past(mode_r))
    else $error("bad second key changed mode");
  key_guard_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (key_wr.valid && mode_r != SMK_FULL)
    |=> key_store_r[$past(key_wr.idx)] == $past(key_store_r[key_wr.idx]) && key_wr_nack)
    else $error("key updated outside full access");
  swap_cmp_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hit_un1 == ({ctl_wr.data[7:0], ctl_wr.data[15:8]} == key_store_r[KIDX_UNSEAL_1]))
    else $error("key compare not byte swapped");
  fbm_sealed_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (flash_block_mode_select && mode_r == SMK_SEALED) |=> flash_block_mode_nack
    && !flash_block_mode_ack)
    else $error("flash block mode accepted while sealed");
  perm_sealed_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sealed_flag |-> !perm.gen_rd && !perm.gen_wr && !perm.blk_a_wr && perm.blk_b_wr)
    else $error("sealed permissions wrong");
  key_land_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    key_upd_ok |=> key_wr_ack && key_store_r[$past(key_wr.idx)] == $past(key_wr.data))
    else $error("key update in full access did not land");
  fbm_open_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (flash_block_mode_select && mode_r != SMK_SEALED) |=> flash_block_mode_ack
    && !flash_block_mode_nack)
    else $error("flash block mode refused while unsealed");

  unseal_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    mode_r == SMK_SEALED ##1 mode_r == SMK_UNSEALED);
  full_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    mode_r == SMK_UNSEALED ##1 mode_r == SMK_FULL);
  key_upd_c: cover property (@(posedge ref_clk) disable iff (!rst_n) key_wr_ack);
  discard_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    ctl_wr.valid && first_ok_r && !second_un && !second_fa);
  seal_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    mode_r != SMK_SEALED ##1 mode_r == SMK_SEALED);

endmodule

/* dv/smk_host_model.sv */
/*
  Host side model: writes control words and key pairs on ctl_wr.
  Assumes ref_clk from the bench; drives 1 ns after each rising edge.
*/
`timescale 1ns/10ps
module smk_host_model (
  input wire logic ref_clk,
  output smk_pkg::smk_ctl_wr_s ctl_wr
);
  import smk_pkg::*;
  initial begin
    ctl_wr = '0;
  end
  // Wire order is the reverse of the stored order
  function automatic logic [15:0] swap(input logic [15:0] v);
    return {v[7:0], v[15:8]};
  endfunction
  //////////////////////////////////////////////////////////////////
  task automatic word(input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    ctl_wr.valid = 1'b1;
    ctl_wr.data = d;
    @(posedge ref_clk);
    #1;
    ctl_wr.valid = 1'b0;
    // Released data must not look like the last word
    ctl_wr.data = ~d;
  endtask
  // Stored key 1 goes first; brk puts a stray write between the two
  task automatic send_pair(input logic [15:0] k1, input logic [15:0] k0, input bit brk);
    word(swap(k1));
    if (brk) begin
      word(16'h0000);
    end
    word(swap(k0));
  endtask
endmodule

/* dv/tb_security_mode_key_unlock.sv */
/*
  Self-checking bench for the key unlock block with a host model.
  Assumes the design modules from design/ and smk_pkg compiled first.
*/
`timescale 1ns/10ps
module tb_security_mode_key_unlock;
  import smk_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  smk_ctl_wr_s ctl_wr;
  smk_key_wr_s key_wr = '0;
  logic seal_req = 1'b0;
  logic flash_block_mode_select = 1'b0;
  logic sealed_flag, full_access_state_flag, key_wr_ack, key_wr_nack;
  logic flash_block_mode_ack, flash_block_mode_nack;
  smk_perm_s perm;
  int fails = 0;
  int total_checks = 0;
  always #2 ref_clk = ~ref_clk;
  smk_unlock dut (.ref_clk(ref_clk), .rst_n(rst_n), .ctl_wr(ctl_wr), .key_wr(key_wr),
    .seal_req(seal_req), .flash_block_mode_select(flash_block_mode_select),
    .sealed_flag(sealed_flag), .full_access_state_flag(full_access_state_flag),
    .key_wr_ack(key_wr_ack), .key_wr_nack(key_wr_nack),
    .flash_block_mode_ack(flash_block_mode_ack),
    .flash_block_mode_nack(flash_block_mode_nack), .perm(perm));
  smk_host_model host (.ref_clk(ref_clk), .ctl_wr(ctl_wr));
  //////////////////////////////////////////////////////////////////
  // Flags and permissions expected for a mode
  function automatic logic [31:0] exp_st(input logic s, input logic f);
    return {24'h0, s, f, (s ? 6'h0b : 6'h3f)};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic st(input logic s, input logic f);
    check({24'h0, sealed_flag, full_access_state_flag, perm}, exp_st(s, f));
  endtask
  // 0 key update, 1 flash mode select, 2 seal; ack/nack seen one cycle on
  task automatic pulse(input int w, input logic [1:0] idx, input logic [15:0] d,
    input logic [1:0] exp);
    @(posedge ref_clk);
    #1;
    if (w == 0) key_wr = '{1'b1, idx, d};
    else if (w == 1) flash_block_mode_select = 1'b1;
    else seal_req = 1'b1;
    @(posedge ref_clk);
    #1;
    key_wr = '{1'b0, ~idx, ~d};
    flash_block_mode_select = 1'b0;
    seal_req = 1'b0;
    if (w == 0) check({30'h0, key_wr_ack, key_wr_nack}, {30'h0, exp});
    else if (w == 1) check({30'h0, flash_block_mode_ack, flash_block_mode_nack}, {30'h0, exp});
  endtask
  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] uk0, uk1, nk0, nk1;
    uk0 = UNSEAL_KEY0_RST;
    uk1 = UNSEAL_KEY1_RST;
    void'($urandom(32'h841f952b));
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    st(1'b1, 1'b1);
    pulse(0, KIDX_UNSEAL_0, 16'h1234, 2'b01);
    pulse(1, 2'h0, 16'h0, 2'b01);
    $display("test sealed refusals done");
    host.send_pair(uk0, uk1, 1'b0);
    st(1'b1, 1'b1);
    host.send_pair(uk1, uk0, 1'b1);
    st(1'b1, 1'b1);
    host.send_pair(uk1, ~uk0, 1'b0);
    st(1'b1, 1'b1);
    host.send_pair(FULL_KEY1_RST, FULL_KEY0_RST, 1'b0);
    st(1'b1, 1'b1);
    $display("test broken pairs done");
    host.send_pair(uk1, uk0, 1'b0);
    st(1'b0, 1'b1);
    pulse(1, 2'h0, 16'h0, 2'b10);
    pulse(0, KIDX_UNSEAL_0, 16'h1234, 2'b01);
    host.send_pair(FULL_KEY1_RST, FULL_KEY0_RST, 1'b0);
    st(1'b0, 1'b0);
    $display("test unseal and full access done");
    // Top bit set keeps keys clear of small subcommand codes
    nk0 = {8'h80 | 8'($urandom), 8'($urandom)};
    nk1 = {8'h80 | 8'($urandom), 8'($urandom)};
    pulse(0, KIDX_UNSEAL_0, nk0, 2'b10);
    pulse(0, KIDX_UNSEAL_1, nk1, 2'b10);
    pulse(2, 2'h0, 16'h0, 2'b00);
    st(1'b1, 1'b1);
    host.send_pair(uk1, uk0, 1'b0);
    st(1'b1, 1'b1);
    host.send_pair(nk1, nk0, 1'b0);
    st(1'b0, 1'b1);
    $display("test key update done");
    report_and_stop();
  end
endmodule
